//--- hw/sleep_core.sv
`timescale 1ns/1ps
// Function
// - Enabled option and selected pin high puts the device into power-down.
// - Power-down holds every output value and internal register state.
// - Outputs in high impedance at entry stay high impedance throughout.
// - All inputs except the active pin are ignored while powered down.
// - Pin hold latches keep every input pin at its last level; the code holds only PAD_I, on KEEP_O.
// - Feature exists only when selected; either of two pins may control.
// - The control pin's logic input is not used by the design.
// - Outputs valid again within 1 us after the pin falls.
// - Inputs, enables and clocks accepted again within 1 us after fall.
module sleep_core #(
  parameter int W = 8
) (
  input  wire logic         SYS_CLK_I,     // 25 MHz clock
  input  wire logic         RESET_I,       // Sync reset, active high
  input  wire logic         CE_I,          // Clock enable
  input  wire logic         SLEEP_EN_I,    // Power-down option enabled
  input  wire logic         SLEEP_SEL_I,   // 0 first pin, 1 second
  input  wire logic         SLEEP_PIN_FIRST_I,  // First candidate pin
  input  wire logic         SLEEP_PIN_SECOND_I, // Second candidate pin
  input  wire logic [W-1:0] DATA_I,        // User logic inputs
  input  wire logic [W-1:0] LOAD_I,        // Per-bit register load
  input  wire logic [W-1:0] OE_I,          // Per-bit output enable request
  input  wire logic [W-1:0] PAD_I,         // Two-way pad input level
  output logic      [W-1:0] PAD_O,         // Two-way pad output value
  output logic      [W-1:0] PAD_OE_O,      // Two-way pad drive enable
  output logic      [W-1:0] KEEP_O,        // Held pad input level
  output logic              ASLEEP_O,      // Device powered down or waking
  output logic              READY_O        // Device fully awake
);
  sleep_if sif ();
  logic    pin_a_sel;
  logic    pin_b_sel;

  // ----------------------------------------------------------------
  // Control pin gating
  // ----------------------------------------------------------------
  // Control pin feeds only the sequencer and the wake interval watch, never user logic
  assign pin_a_sel = SLEEP_PIN_FIRST_I;
  assign pin_b_sel = SLEEP_PIN_SECOND_I;

  sleep_ctrl u_ctrl (
    .clk_i    (SYS_CLK_I),
    .rst_i    (RESET_I),
    .ce_i     (CE_I),
    .enable_i (SLEEP_EN_I),
    .sel_i    (SLEEP_SEL_I),
    .pin_a_i  (pin_a_sel),
    .pin_b_i  (pin_b_sel),
    .sif      (sif)
  );

  logic [W-1:0] q_r, q_nxt;
  logic [W-1:0] oe_r, oe_nxt;
  logic [W-1:0] keep_r, keep_nxt;
  logic         asleep_r, asleep_nxt;
  logic         ready_r, ready_nxt;

  // ----------------------------------------------------------------
  // Macrocell registers, per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_cell
    always_comb begin
      if (sif.frozen) begin
        q_nxt[i]    = q_r[i];
        oe_nxt[i]   = oe_r[i];
        keep_nxt[i] = keep_r[i];
      end else begin
        q_nxt[i]    = LOAD_I[i] ? DATA_I[i] : q_r[i];
        oe_nxt[i]   = OE_I[i];
        keep_nxt[i] = PAD_I[i];
      end
    end
  end

  always_comb begin
    asleep_nxt = sif.frozen;
    ready_nxt  = !sif.frozen;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      q_r      <= {W{sleep_pkg::RST_LEVEL}};
      oe_r     <= {W{sleep_pkg::RST_OE}};
      keep_r   <= {W{sleep_pkg::RST_LEVEL}};
      asleep_r <= 1'b0;
      ready_r  <= 1'b1;
    end else if (CE_I) begin
      // No reset path on wake: held values simply carry on
      q_r      <= q_nxt;
      oe_r     <= oe_nxt;
      keep_r   <= keep_nxt;
      asleep_r <= asleep_nxt;
      ready_r  <= ready_nxt;
    end
  end

  assign PAD_O    = q_r;
  assign PAD_OE_O = oe_r;
  assign KEEP_O   = keep_r;
  assign ASLEEP_O = asleep_r;
  assign READY_O  = ready_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hold_data: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && sif.frozen |=> $stable(q_r))
    else $error("Register changed while asleep");
  a_hold_hiz: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && sif.frozen && !oe_r[0] |=> !oe_r[0])
    else $error("High impedance output enabled while asleep");
  a_keep_level: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && sif.frozen |=> keep_r == $past(keep_r))
    else $error("Pin keeper changed while asleep");
  a_input_block: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && sif.frozen && (LOAD_I != '0) |=> q_r == $past(q_r))
    else $error("Input took effect while asleep");
  a_wake_ready: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && !sif.frozen |=> ready_r)
    else $error("Ready missing after wake");
  a_resume_state: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    CE_I && $fell(sif.frozen) && (LOAD_I == '0) |=> q_r == $past(q_r))
    else $error("State lost on wake");

  for (genvar i = 0; i < W; i++) begin : g_hiz_chk
    a_hold_hiz_bit: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
      CE_I && sif.frozen && !oe_r[i] |=> !oe_r[i])
      else $error("High impedance bit enabled while asleep");
  end

  // ----------------------------------------------------------------
  // Wake interval watch
  // ----------------------------------------------------------------
  logic                             pin_now;
  logic                             sleep_want;
  logic [sleep_pkg::WAKE_CNT_W-1:0] wake_seen_r, wake_seen_nxt;

  always_comb begin
    pin_now       = (SLEEP_SEL_I == sleep_pkg::SEL_SECOND) ? pin_b_sel : pin_a_sel;
    sleep_want    = SLEEP_EN_I & pin_now;
    wake_seen_nxt = '0;
    if (sif.frozen && !sleep_want) begin
      wake_seen_nxt = (wake_seen_r == '1) ? wake_seen_r : wake_seen_r + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      wake_seen_r <= '0;
    end else if (CE_I) begin
      wake_seen_r <= wake_seen_nxt;
    end
  end

  a_wake_limit: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    wake_seen_r < sleep_pkg::WAKE_CYCLES)
    else $error("Wake interval too long");

  // ----------------------------------------------------------------
  // Entry and release sequences
  // ----------------------------------------------------------------
  sequence s_pin_held;
    CE_I && sleep_want ##1 CE_I;
  endsequence

  sequence s_live_load;
    CE_I && !sif.frozen && LOAD_I[0];
  endsequence

  a_asleep_flag: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    s_pin_held |=> ASLEEP_O)
    else $error("Asleep flag missing");
  a_live_input: assert property (@(posedge SYS_CLK_I) disable iff (RESET_I)
    s_live_load |=> PAD_O[0] == $past(DATA_I[0]))
    else $error("Input ignored while awake");
endmodule : sleep_core

//--- hw/sleep_pkg.sv
package sleep_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WAKE_MAX_NS     = 1000;
  // Longest time rounds down, never below one cycle
  localparam int WAKE_CYCLES_RAW = WAKE_MAX_NS / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES     = (WAKE_CYCLES_RAW < 1) ? 1 : WAKE_CYCLES_RAW;
  localparam int WAKE_CNT_W      = 6;
  // Last wake count; pin input and output flops take the other edges
  localparam int WAKE_LAST       = WAKE_CYCLES - 3;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_LEVEL     = 1'b0;
  localparam logic RST_OE        = 1'b0;
  // ----------------------------------------------------------------
  // Pin select encoding
  // ----------------------------------------------------------------
  localparam logic SEL_FIRST     = 1'b0;
  localparam logic SEL_SECOND    = 1'b1;
endpackage : sleep_pkg

//--- hw/sleep_if.sv
`timescale 1ns/1ps
interface sleep_if;
  logic frozen;   // Hold all state
  logic waking;   // Wake interval running
  modport ctrl (output frozen, output waking);
  modport user (input frozen, input waking);
endinterface : sleep_if

//--- hw/sleep_ctrl.sv
`timescale 1ns/1ps
module sleep_ctrl (
  input  wire logic   clk_i,     // System clock
  input  wire logic   rst_i,     // Sync reset, active high
  input  wire logic   ce_i,      // Clock enable
  input  wire logic   enable_i,  // Power-down option selected
  input  wire logic   sel_i,     // Which pin controls
  input  wire logic   pin_a_i,   // First candidate pin
  input  wire logic   pin_b_i,   // Second candidate pin
  sleep_if.ctrl       sif        // State to the core
);
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b10
  } st_e;

  st_e                              st_r, st_nxt;
  logic [sleep_pkg::WAKE_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                             req;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    req     = enable_i & ((sel_i == sleep_pkg::SEL_SECOND) ? pin_b_i : pin_a_i);
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_RUN: begin
        if (req) begin
          st_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!req) begin
          st_nxt  = ST_WAKE;
          cnt_nxt = '0;
        end
      end
      ST_WAKE: begin
        if (req) begin
          st_nxt = ST_SLEEP;
        end else if (cnt_r == sleep_pkg::WAKE_CNT_W'(sleep_pkg::WAKE_LAST)) begin
          st_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r  <= ST_RUN;
      cnt_r <= '0;
    end else if (ce_i) begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sif.frozen = (st_r != ST_RUN);
  assign sif.waking = (st_r == ST_WAKE);

  a_wake_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_WAKE) && ce_i && !req && (cnt_r == sleep_pkg::WAKE_CNT_W'(sleep_pkg::WAKE_LAST))
      |=> st_r == ST_RUN)
    else $error("Wake interval exceeded");
  a_sleep_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && req |=> st_r == ST_SLEEP)
    else $error("Sleep request not honoured");
endmodule : sleep_ctrl

//--- testbench/sleep_host.sv
`timescale 1ns/1ps
module sleep_host (
  input  wire logic clk_i,    // System clock
  input  wire logic req_i,    // Sleep wanted
  input  wire logic sel_i,    // 0 first pin, 1 second
  input  wire logic stray_i,  // Level on the unused pin
  output logic      first_o,  // First candidate pin
  output logic      second_o  // Second candidate pin
);
  // Only the chosen pin carries the request
  always_ff @(posedge clk_i) begin
    first_o  <= (sel_i == sleep_pkg::SEL_FIRST) ? req_i : stray_i;
    second_o <= (sel_i == sleep_pkg::SEL_SECOND) ? req_i : stray_i;
  end
endmodule : sleep_host

//--- testbench/sleep_core_bench.sv
`timescale 1ns/1ps
module sleep_core_bench;
  typedef struct packed {logic [7:0] d, l, o, p, eq, eo, ek;} row_s;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, en = 1'b1;
  logic       sel = 1'b0, req = 1'b0, stray = 1'b0;
  logic       first, second, asleep, ready;
  logic [7:0] data = 8'h00, load = 8'h00, oe = 8'h00, pad = 8'h00, q, qoe, keep;
  int         mismatches = 0;
  int         compares = 0;
  int         n;
  row_s       rows [5] = '{
    '{8'ha5, 8'hff, 8'h0f, 8'h3c, 8'ha5, 8'h0f, 8'h3c},
    '{8'h5a, 8'h0f, 8'hf0, 8'hc3, 8'haa, 8'hf0, 8'hc3},
    '{8'hff, 8'h00, 8'hff, 8'h00, 8'haa, 8'hff, 8'h00},
    '{8'h00, 8'hf0, 8'h00, 8'hff, 8'h0a, 8'h00, 8'hff},
    '{8'h12, 8'hff, 8'h33, 8'h99, 8'h12, 8'h33, 8'h99}};

  always #20 clk = ~clk;

  sleep_host host (.clk_i(clk), .req_i(req), .sel_i(sel), .stray_i(stray),
                   .first_o(first), .second_o(second));
  sleep_core DUT (.SYS_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .SLEEP_EN_I(en),
                  .SLEEP_SEL_I(sel), .SLEEP_PIN_FIRST_I(first), .SLEEP_PIN_SECOND_I(second),
                  .DATA_I(data), .LOAD_I(load), .OE_I(oe), .PAD_I(pad), .PAD_O(q),
                  .PAD_OE_O(qoe), .KEEP_O(keep), .ASLEEP_O(asleep), .READY_O(ready));

  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task apply(input row_s r);
    @(posedge clk);
    data <= r.d; load <= r.l; oe <= r.o; pad <= r.p;
    repeat (2) @(posedge clk);
    #1;
  endtask : apply

  task nap(input logic s);
    apply(rows[4]);
    @(posedge clk);
    sel <= s;
    req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("asleep", {7'h00, asleep}, 8'h01);
    chk("ready", {7'h00, ready}, 8'h00);
    @(posedge clk);
    data <= 8'hed; load <= 8'h0f; oe <= 8'hff; pad <= 8'h66;
    repeat (4) @(posedge clk);
    #1;
    chk("q held", q, 8'h12);
    chk("oe held", qoe, 8'h33);
    chk("keep held", keep, 8'h99);
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
      if (ready !== 1'b1) chk("q in wake", q, 8'h12);
    end
    chk("wake time", 8'(n), 8'h1a);
    chk("q resumed", q, 8'h1d);
    repeat (2) @(posedge clk);
    #1;
    chk("q live", q, 8'h1d);
    chk("oe live", qoe, 8'hff);
    chk("keep live", keep, 8'h66);
  endtask : nap

  task tally_and_finish;
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset q", q | qoe | keep, 8'h00);
    chk("reset ready", {6'h00, asleep, ready}, 8'h01);
    foreach (rows[i]) begin
      apply(rows[i]);
      chk("q", q, rows[i].eq);
      chk("oe", qoe, rows[i].eo);
      chk("keep", keep, rows[i].ek);
    end
    nap(1'b0);
    nap(1'b1);
    @(posedge clk);
    en <= 1'b0;
    sel <= 1'b0;
    req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("disabled", {7'h00, asleep}, 8'h00);
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    stray <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("other pin", {7'h00, asleep}, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    data <= 8'h44;
    repeat (3) @(posedge clk);
    #1;
    chk("ce frozen", q, 8'h1d);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("ce running", q, 8'h14);
    tally_and_finish();
  end

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule : sleep_core_bench
